// *** babc_batt_model.sv ***
// Battery divider model feeding the two raw comparator outputs.
// Assumes the bench sets the battery condition for each threshold.
`timescale 1ns/1ps
module babc_batt_model (
   input  wire i_pwr_one,
   input  wire i_pwr_two,
   input  wire i_one_low,
   input  wire i_two_low,
   output wire o_one_below,
   output wire o_two_below
);
   // An unpowered comparator floats high, which would look like an alarm.
   assign o_one_below = i_pwr_one ? i_one_low : 1'b1;
   assign o_two_below = i_pwr_two ? i_two_low : 1'b1;
endmodule // babc_batt_model

// *** babc_defs.vh ***
// Constants for the battery alarm comparator control block.
// Assumes a 20 MHz core clock and a link frame strobe at 48k frames/s.
// Summary of operation
// RULE1 - Dead battery alarm drives GPIO status bit 15, low battery bit 14.
// RULE2 - Alarm status feeds GPIO interrupt logic and can request wake-up.
// RULE3 - Reference select bit 14 or 11, default 0: midrail, 1: external pin.
// RULE4 - Source bits 13:12: 00 off unless reference 1, else pin one to three.
// RULE5 - Source bits 10:9 decode like comparator one, 00 off unless reference.
// RULE6 - Polarity bit 15, default 1: alarm below reference, 0: above.
// RULE7 - Polarity bit 14, default 1: alarm below reference, 0: above.
// RULE8 - Delay bits 15:13: 000 none, else 2^13 to 2^19 link frames.
// RULE9 - Delay counts link frames at a fixed 48k rate, whatever the audio rate.
// RULE10 - Nonzero delay: count, recheck, set bit only if the alarm persists.
// RULE11 - A delayed trigger in sleep starts the oscillator so counting proceeds.
// RULE12 - Comparator status bits are active only while that comparator is on.
// RULE13 - Comparator outputs pass two flip-flops before any logic uses them.
// RULE14 - Delay count restarts from zero on a new alarm when not counting.
`ifndef BABC_DEFS_VH
`define BABC_DEFS_VH

`define BABC_ADDR_POLARITY     7'h4E
`define BABC_ADDR_ADD_FUNC     7'h58
`define BABC_ADDR_CMP_SELECT   7'h5A

`define BABC_POL_ONE_BIT       15
`define BABC_POL_TWO_BIT       14
`define BABC_POL_RESET         16'hFFFF

`define BABC_DELAY_HI          15
`define BABC_DELAY_LO          13
`define BABC_WAKE_EN_BIT       1
`define BABC_ADD_FUNC_RESET    16'h0000

`define BABC_ONE_REF_BIT       14
`define BABC_ONE_SRC_HI        13
`define BABC_ONE_SRC_LO        12
`define BABC_TWO_REF_BIT       11
`define BABC_TWO_SRC_HI        10
`define BABC_TWO_SRC_LO        9
`define BABC_SELECT_MASK       16'h7E00
`define BABC_SELECT_RESET      16'h0000

`define BABC_DELAY_BASE_EXP    12
`define BABC_DELAY_CNT_W       20
`define BABC_SETTLE_LAST       2'h3

`endif

// *** babc_monitor.sv ***
// Checker on the ports of the battery alarm comparator control.
// Assumes it is bound into babc_top.
`timescale 1ns/1ps
module babc_monitor (
   input wire        I_CLK,
   input wire        I_RST,
   input wire        I_REG_WR,
   input wire        I_REG_RD,
   input wire [6:0]  I_REG_ADDR,
   input wire [15:0] I_REG_WDATA,
   input wire        I_SLEEP,
   input wire        I_CMP_ONE_BELOW,
   input wire [15:0] O_REG_RDATA,
   input wire        O_CMP_ONE_PWR_EN,
   input wire        O_CMP_ONE_REF_SEL,
   input wire [1:0]  O_CMP_ONE_SRC_SEL,
   input wire        O_CMP_TWO_PWR_EN,
   input wire        O_CMP_TWO_REF_SEL,
   input wire [1:0]  O_CMP_TWO_SRC_SEL,
   input wire        O_GPIO_STATUS15,
   input wire        O_GPIO_STATUS14,
   input wire        O_WAKE_REQ,
   input wire        O_OSC_REQ
);
   logic [2:0] quiet_r;
   // Counts cycles since the last register write.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) quiet_r <= 3'h0;
      else if (I_REG_WR) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   property p_pwr_one;
      O_CMP_ONE_PWR_EN == (O_CMP_ONE_SRC_SEL != 2'h0 || O_CMP_ONE_REF_SEL);
   endproperty
   a_pwr_one: assert property (p_pwr_one) else $error("pwr one");
   property p_pwr_two;
      O_CMP_TWO_PWR_EN == (O_CMP_TWO_SRC_SEL != 2'h0 || O_CMP_TWO_REF_SEL);
   endproperty
   a_pwr_two: assert property (p_pwr_two) else $error("pwr two");
   property p_sel_wr;
      (I_REG_WR && I_REG_ADDR == 7'h5A) ##1 !I_REG_WR |=>
         {O_CMP_ONE_REF_SEL, O_CMP_ONE_SRC_SEL, O_CMP_TWO_REF_SEL,
          O_CMP_TWO_SRC_SEL} == $past(I_REG_WDATA[14:9], 2);
   endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("select");
   property p_rd_mask;
      I_REG_RD && I_REG_ADDR == 7'h5A |=> (O_REG_RDATA & 16'h81FF) == 16'h0;
   endproperty
   a_rd_mask: assert property (p_rd_mask) else $error("mask");
   property p_st15_pwr;
      O_GPIO_STATUS15 |-> O_CMP_ONE_PWR_EN;
   endproperty
   a_st15_pwr: assert property (p_st15_pwr) else $error("st15");
   property p_st14_pwr;
      O_GPIO_STATUS14 |-> O_CMP_TWO_PWR_EN;
   endproperty
   a_st14_pwr: assert property (p_st14_pwr) else $error("st14");
   property p_osc;
      O_OSC_REQ |-> $past(I_SLEEP);
   endproperty
   a_osc: assert property (p_osc) else $error("osc");
   property p_wake;
      O_WAKE_REQ |-> O_GPIO_STATUS15 || O_GPIO_STATUS14 ||
         $past(O_GPIO_STATUS15 || O_GPIO_STATUS14);
   endproperty
   a_wake: assert property (p_wake) else $error("wake");
   property p_st15_src;
      $rose(O_GPIO_STATUS15) && quiet_r >= 3'h6 |->
         $past(I_CMP_ONE_BELOW, 3) != $past(I_CMP_ONE_BELOW, 4);
   endproperty
   a_st15_src: assert property (p_st15_src) else $error("src");
endmodule // babc_monitor
bind babc_top babc_monitor babc_monitor_inst (.I_CLK, .I_RST, .I_REG_WR,
   .I_REG_RD, .I_REG_ADDR, .I_REG_WDATA, .I_SLEEP, .I_CMP_ONE_BELOW,
   .O_REG_RDATA, .O_CMP_ONE_PWR_EN, .O_CMP_ONE_REF_SEL, .O_CMP_ONE_SRC_SEL,
   .O_CMP_TWO_PWR_EN, .O_CMP_TWO_REF_SEL, .O_CMP_TWO_SRC_SEL,
   .O_GPIO_STATUS15, .O_GPIO_STATUS14, .O_WAKE_REQ, .O_OSC_REQ);

// *** babc_sync.v ***
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are quasi-static comparator levels.
`timescale 1ns/1ps
module babc_sync #(
   parameter W = 2
) (
   input  wire         i_clk,
   input  wire         i_rst,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // The first stage is read only by the second stage.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= i_async; // RULE13
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;
endmodule // babc_sync

// *** babc_tb_top.sv ***
// Testbench for the battery alarm comparator control.
// Assumes a 20 MHz clock and one frame tick per cycle to shorten delays.
`timescale 1ns/1ps
module babc_tb_top;
   reg         clk, rst, wr, rd, tick, slp, lo1, lo2;
   reg  [6:0]  addr;
   reg  [15:0] wd;
   wire [15:0] rdat;
   wire        p1, r1, p2, r2, s15, s14, wake, osc, b1, b2;
   wire [1:0]  c1, c2;
   integer     n_errors, checks, cyc, i;
   babc_top babc_top_inst (.I_CLK(clk), .I_RST(rst), .I_REG_WR(wr),
      .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
      .I_FRAME_TICK(tick), .I_SLEEP(slp), .I_CMP_ONE_BELOW(b1),
      .I_CMP_TWO_BELOW(b2), .O_REG_RDATA(rdat), .O_CMP_ONE_PWR_EN(p1),
      .O_CMP_ONE_REF_SEL(r1), .O_CMP_ONE_SRC_SEL(c1),
      .O_CMP_TWO_PWR_EN(p2), .O_CMP_TWO_REF_SEL(r2),
      .O_CMP_TWO_SRC_SEL(c2), .O_GPIO_STATUS15(s15),
      .O_GPIO_STATUS14(s14), .O_WAKE_REQ(wake), .O_OSC_REQ(osc));
   babc_batt_model babc_batt_model_inst (.i_pwr_one(p1), .i_pwr_two(p2),
      .i_one_low(lo1), .i_two_low(lo2), .o_one_below(b1), .o_two_below(b2));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task ck(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input [15:0] v, input [15:0] e);
      checks = checks + 1;
      if (v !== e) begin
         n_errors = n_errors + 1;
         $display("[ERR] %0t got %h want %h", $time, v, e);
      end
   endtask
   task wrr(input [6:0] a, input [15:0] d);
      ck(1);
      wr = 1'b1; addr = a; wd = d;
      ck(1);
      wr = 1'b0;
      ck(2);
   endtask
   task rdc(input [6:0] a, input [15:0] e);
      ck(1);
      rd = 1'b1; addr = a;
      ck(1);
      rd = 1'b0;
      chk(rdat, e);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task t_regs;
      rdc(7'h4E, 16'hFFFF);
      rdc(7'h58, 16'h0000);
      rdc(7'h5A, 16'h0000);
      rdc(7'h10, 16'h0000);
      chk({p1, p2, s15, s14}, 16'h0);
      wrr(7'h5A, 16'hFFFF);
      rdc(7'h5A, 16'h7E00);
      for (i = 0; i < 8; i = i + 1) begin
         wrr(7'h5A, {1'b0, i[2:0], i[2:0], 9'h0});
         chk({p1, r1, c1}, {i != 0, i[2:0]});
         chk({p2, r2, c2}, {i != 0, i[2:0]});
      end
      $display("t_regs done");
   endtask
   task t_one;
      wrr(7'h5A, 16'h1000);
      lo1 = 1'b1; ck(6); chk({s15, wake}, 2'h2);
      wrr(7'h4E, 16'h7FFF); ck(4); chk(s15, 0);
      lo1 = 1'b0; ck(6); chk(s15, 1);
      wrr(7'h4E, 16'hFFFF); ck(6); chk(s15, 0);
      lo1 = 1'b1; ck(6); chk(s15, 1);
      wrr(7'h5A, 16'h0000); chk(s15, 0);
      $display("t_one done");
   endtask
   task t_two;
      wrr(7'h58, 16'h0002);
      wrr(7'h5A, 16'h0200);
      lo2 = 1'b1; ck(6); chk({s14, wake}, 3);
      wrr(7'h4E, 16'hBFFF); ck(4); chk(s14, 0);
      wrr(7'h4E, 16'hFFFF); lo2 = 1'b0;
      wrr(7'h58, 16'h2002); ck(4);
      lo2 = 1'b1; ck(100); chk(s14, 0);
      slp = 1'b1; ck(3); chk(osc, 1);
      slp = 1'b0; ck(8085); chk({s14, osc}, 0);
      ck(10); chk({s14, wake}, 3);
      lo2 = 1'b0; ck(6); chk(s14, 0);
      lo2 = 1'b1; ck(50); lo2 = 1'b0;
      ck(8145); chk({s14, wake}, 0);
      ck(155); chk(s14, 0);
      lo2 = 1'b1; ck(8188); chk(s14, 0);
      ck(10); chk(s14, 1);
      $display("t_two done");
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         n_errors = n_errors + 1;
         wrap_up;
      end
   end
   initial begin
      {wr, rd, tick, slp, lo1, lo2, addr, wd} = 0;
      n_errors = 0; checks = 0; cyc = 0;
      rst = 1'b1;
      ck(16);
      rst = 1'b0;
      tick = 1'b1;
      t_regs;
      t_one;
      t_two;
      wrap_up;
   end
endmodule // babc_tb_top

// *** babc_top.v ***
// Battery alarm comparator control: registers, polarity, power and delay.
// Assumes register accesses and frame strobes come from link logic on I_CLK.
`timescale 1ns/1ps
`include "babc_defs.vh"
module babc_top (
   input  wire        I_CLK,
   input  wire        I_RST,
   input  wire        I_REG_WR,
   input  wire        I_REG_RD,
   input  wire [6:0]  I_REG_ADDR,
   input  wire [15:0] I_REG_WDATA,
   input  wire        I_FRAME_TICK,
   input  wire        I_SLEEP,
   input  wire        I_CMP_ONE_BELOW,
   input  wire        I_CMP_TWO_BELOW,
   output reg  [15:0] O_REG_RDATA,
   output reg         O_CMP_ONE_PWR_EN,
   output reg         O_CMP_ONE_REF_SEL,
   output reg  [1:0]  O_CMP_ONE_SRC_SEL,
   output reg         O_CMP_TWO_PWR_EN,
   output reg         O_CMP_TWO_REF_SEL,
   output reg  [1:0]  O_CMP_TWO_SRC_SEL,
   output reg         O_GPIO_STATUS15,
   output reg         O_GPIO_STATUS14,
   output reg         O_WAKE_REQ,
   output reg         O_OSC_REQ
);
   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_COUNT  = 3'b010;
   localparam [2:0] ST_ACTIVE = 3'b100;

   reg  [15:0] polarity_r;
   reg  [15:0] add_func_r;
   reg  [15:0] select_r;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [`BABC_DELAY_CNT_W-1:0] count_r;
   reg  [`BABC_DELAY_CNT_W-1:0] count_nxt;
   reg         status14_nxt;
   reg  [15:0] rdata_nxt;
   wire [1:0]  below_sync;
   wire        one_on;
   wire        two_on;
   wire        alarm_one;
   wire        alarm_two;
   wire [2:0]  delay_code;
   wire [`BABC_DELAY_CNT_W-1:0] delay_last;
   reg  [1:0]  one_settle_r;
   reg  [1:0]  two_settle_r;
   wire        one_ready;
   wire        two_ready;
   wire        sel_wr;

   // Frames in the delay minus one; code 000 ends a running count at the next frame strobe.
   function [`BABC_DELAY_CNT_W-1:0] delay_frames_m1;
      input [2:0] code;
      reg   [`BABC_DELAY_CNT_W-1:0] one;
      begin
         one = {{(`BABC_DELAY_CNT_W-1){1'b0}}, 1'b1};
         if (code == 3'h0) begin
            delay_frames_m1 = {`BABC_DELAY_CNT_W{1'b0}};
         end else begin
            delay_frames_m1 = (one << (`BABC_DELAY_BASE_EXP + code)) - one;
         end
      end
   endfunction

   // A comparator runs when a source pin or the external reference is chosen.
   function cmp_powered;
      input [1:0] src;
      input       ref_sel;
      begin
         cmp_powered = (src != 2'h0) | ref_sel;
      end
   endfunction

   // Alarm when the input is below the reference with polarity 1, else above.
   function cmp_alarm;
      input below;
      input pol;
      begin
         cmp_alarm = pol ? below : ~below;
      end
   endfunction

   // Settling count: cleared while off or on a new selection, then saturates.
   function [1:0] settle_next;
      input [1:0] cnt;
      input       on;
      input       restart;
      begin
         if (!on || restart) begin
            settle_next = 2'h0;
         end else if (cnt != `BABC_SETTLE_LAST) begin
            settle_next = cnt + 2'h1;
         end else begin
            settle_next = cnt;
         end
      end
   endfunction

   babc_sync #(
      .W (2)
   ) u_sync (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_async ({I_CMP_TWO_BELOW, I_CMP_ONE_BELOW}),
      .o_sync  (below_sync)
   );

   assign one_on = cmp_powered(
      select_r[`BABC_ONE_SRC_HI:`BABC_ONE_SRC_LO],
      select_r[`BABC_ONE_REF_BIT]);                       // RULE4
   assign two_on = cmp_powered(
      select_r[`BABC_TWO_SRC_HI:`BABC_TWO_SRC_LO],
      select_r[`BABC_TWO_REF_BIT]);                       // RULE5
   assign alarm_one = one_on & one_ready &
      cmp_alarm(below_sync[0], polarity_r[`BABC_POL_ONE_BIT]); // RULE6
   assign alarm_two = two_on & two_ready &
      cmp_alarm(below_sync[1], polarity_r[`BABC_POL_TWO_BIT]); // RULE7
   assign delay_code = add_func_r[`BABC_DELAY_HI:`BABC_DELAY_LO];
   assign delay_last = delay_frames_m1(delay_code);      // RULE8
   assign sel_wr     = I_REG_WR & (I_REG_ADDR == `BABC_ADDR_CMP_SELECT);
   assign one_ready  = (one_settle_r == `BABC_SETTLE_LAST);   // RULE13
   assign two_ready  = (two_settle_r == `BABC_SETTLE_LAST);   // RULE13

   // Polarity register write.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         polarity_r <= `BABC_POL_RESET;
      end else if (I_REG_WR && (I_REG_ADDR == `BABC_ADDR_POLARITY)) begin
         polarity_r <= I_REG_WDATA;                               // RULE6
      end
   end

   // Additional function register write.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         add_func_r <= `BABC_ADD_FUNC_RESET;
      end else if (I_REG_WR && (I_REG_ADDR == `BABC_ADDR_ADD_FUNC)) begin
         add_func_r <= I_REG_WDATA;                               // RULE8
      end
   end

   // Reference and source select write; unused bits stay zero.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         select_r <= `BABC_SELECT_RESET;
      end else if (sel_wr) begin
         select_r <= I_REG_WDATA & `BABC_SELECT_MASK;             // RULE3
      end
   end

   // Comparator data is trusted only once the synchroniser holds samples
   // taken after power-up or a new selection, so stale levels raise no alarm.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         one_settle_r <= 2'h0;
         two_settle_r <= 2'h0;
      end else begin
         one_settle_r <= settle_next(one_settle_r, one_on, sel_wr); // RULE13
         two_settle_r <= settle_next(two_settle_r, two_on, sel_wr);
      end
   end

   // Read data is captured on a read strobe; unmapped addresses read zero.
   always @* begin
      rdata_nxt = O_REG_RDATA;
      if (I_REG_RD) begin
         case (I_REG_ADDR)
            `BABC_ADDR_POLARITY: begin
               rdata_nxt = polarity_r;
            end
            `BABC_ADDR_ADD_FUNC: begin
               rdata_nxt = add_func_r;
            end
            `BABC_ADDR_CMP_SELECT: begin
               rdata_nxt = select_r;
            end
            default: begin
               rdata_nxt = 16'h0000;
            end
         endcase
      end
   end

   // Low battery delay sequencer, counted in link frame strobes.
   always @* begin
      state_nxt    = state_r;
      count_nxt    = count_r;
      status14_nxt = O_GPIO_STATUS14;
      case (state_r)
         ST_IDLE: begin
            count_nxt = {`BABC_DELAY_CNT_W{1'b0}};              // RULE14
            if (alarm_two) begin
               if (delay_code == 3'h0) begin
                  state_nxt    = ST_ACTIVE;
                  status14_nxt = 1'b1;
               end else begin
                  state_nxt = ST_COUNT;                         // RULE10
               end
            end
         end
         ST_COUNT: begin
            if (I_FRAME_TICK) begin                             // RULE9
               if (count_r >= delay_last) begin
                  count_nxt = {`BABC_DELAY_CNT_W{1'b0}};
                  if (alarm_two) begin
                     state_nxt    = ST_ACTIVE;
                     status14_nxt = 1'b1;                       // RULE10
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end else begin
                  count_nxt = count_r + {{(`BABC_DELAY_CNT_W-1){1'b0}}, 1'b1};
               end
            end
         end
         ST_ACTIVE: begin
            if (!alarm_two) begin
               state_nxt    = ST_IDLE;
               status14_nxt = 1'b0;                             // RULE12
            end
         end
         default: begin
            state_nxt    = ST_IDLE;
            count_nxt    = {`BABC_DELAY_CNT_W{1'b0}};
            status14_nxt = 1'b0;
         end
      endcase
   end

   // Sequencer state.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_r <= ST_IDLE;
         count_r <= {`BABC_DELAY_CNT_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
      end
   end

   // Read data, held until the next read strobe.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_REG_RDATA <= 16'h0000;
      end else begin
         O_REG_RDATA <= rdata_nxt;
      end
   end

   // Comparator one power, reference and source controls.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CMP_ONE_PWR_EN  <= 1'b0;
         O_CMP_ONE_REF_SEL <= 1'b0;
         O_CMP_ONE_SRC_SEL <= 2'h0;
      end else begin
         O_CMP_ONE_PWR_EN  <= one_on;                           // RULE4
         O_CMP_ONE_REF_SEL <= select_r[`BABC_ONE_REF_BIT];      // RULE3
         O_CMP_ONE_SRC_SEL <= select_r[`BABC_ONE_SRC_HI:`BABC_ONE_SRC_LO];
      end
   end

   // Comparator two power, reference and source controls.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CMP_TWO_PWR_EN  <= 1'b0;
         O_CMP_TWO_REF_SEL <= 1'b0;
         O_CMP_TWO_SRC_SEL <= 2'h0;
      end else begin
         O_CMP_TWO_PWR_EN  <= two_on;                           // RULE5
         O_CMP_TWO_REF_SEL <= select_r[`BABC_TWO_REF_BIT];      // RULE3
         O_CMP_TWO_SRC_SEL <= select_r[`BABC_TWO_SRC_HI:`BABC_TWO_SRC_LO];
      end
   end

   // Alarm status bits toward the GPIO logic.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_GPIO_STATUS15 <= 1'b0;
         O_GPIO_STATUS14 <= 1'b0;
      end else begin
         O_GPIO_STATUS15 <= alarm_one;                          // RULE1
         O_GPIO_STATUS14 <= status14_nxt & two_on;              // RULE1
      end
   end

   // Wake and oscillator requests.
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_WAKE_REQ <= 1'b0;
         O_OSC_REQ  <= 1'b0;
      end else begin
         O_WAKE_REQ <= add_func_r[`BABC_WAKE_EN_BIT] &
                       (alarm_one | (status14_nxt & two_on));   // RULE2
         O_OSC_REQ  <= I_SLEEP & state_nxt[1];                  // RULE11
      end
   end
endmodule // babc_top
